// >>> host_model.sv
// host processor side of the register port
`timescale 1ns/100ps
module host_model (
  // clock
  input wire clk_i,
  // register port
  output reg wr_en_o,
  output reg rd_en_o,
  output reg [3:0] addr_o,
  output reg [11:0] wr_data_o,
  input wire [11:0] rd_data_i,
  input wire rd_valid_i
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 4'h0;
    wr_data_o = 12'h000;
  end
  task wr(input [3:0] a, input [11:0] d);
    begin
      @(negedge clk_i);
      addr_o = a;
      wr_data_o = d;
      wr_en_o = 1'b1;
      @(negedge clk_i);
      wr_en_o = 1'b0;
      // stale data must not look valid
      wr_data_o = ~d;
    end
  endtask
  task rd(input [3:0] a, output [11:0] q);
    begin
      @(negedge clk_i);
      addr_o = a;
      rd_en_o = 1'b1;
      @(negedge clk_i);
      rd_en_o = 1'b0;
      q = rd_valid_i ? rd_data_i : 12'hfff;
    end
  endtask
endmodule

// >>> spindle_vcm_regs.v
// status, coil current and spindle control registers with commutation logic
`timescale 1ns/100ps
`include "spindle_vcm_regs_defines.vh"

module spindle_vcm_regs #(
  parameter MASK_CYCLES = `MASK_CYCLES_DEFAULT
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // host register port, behind the serial framing
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [`ADDR_W-1:0] addr_i,
  input wire [`REG_W-1:0] wr_data_i,
  output reg [`REG_W-1:0] rd_data_o,
  output reg rd_valid_o,
  // analog monitors
  input wire thermal_i,
  input wire supply_good_i,
  input wire loop_source_i,
  input wire loop_sink_i,
  input wire back_emf_comparator_i,
  // reset seen by the control logic
  output wire por_active_o,
  // voice coil converter
  output reg [9:0] coil_magnitude_o,
  output reg coil_direction_o,
  output reg coil_range_select_o,
  // spindle converter and charge pump preset
  output wire [7:0] spin_current_limit_o,
  output wire [3:0] commutation_lag_o,
  // spindle half bridges, bit 0 phase a
  output reg [2:0] high_drive_o,
  output reg [2:0] low_drive_o,
  output wire commutate_o
);

  ////////////////////////////////////////////////////////////////////////////
  // power-on reset hold

  wire por_hold;
  reg [`REG_W-1:0] coil_current_command;
  reg [`REG_W-1:0] spindle_control;
  reg speed_reached_flag;
  reg loop_sink_q;
  reg thermal_q;
  reg supply_good_flag;
  reg loop_source_flag;
  reg loop_sink_flag;
  reg back_emf_comparator_state;
  wire mask_active;
  wire delay_active;
  wire [`REG_W-1:0] system_status;

  assign por_hold = ~supply_good_i;
  assign por_active_o = por_hold;

  ////////////////////////////////////////////////////////////////////////////
  // host writes

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      coil_current_command <= `REG_RESET;
      spindle_control <= `REG_RESET;
    end else if (por_hold) begin
      coil_current_command <= `REG_RESET;
      spindle_control <= `REG_RESET;
    end else if (wr_en_i) begin
      case (addr_i)
        `IDX_COIL_CURRENT_COMMAND: begin
          coil_current_command <= wr_data_i;
        end
        `IDX_SPINDLE_CONTROL: begin
          spindle_control <= wr_data_i;
        end
        default: begin
          coil_current_command <= coil_current_command;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status capture

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      thermal_q <= 1'b0;
      supply_good_flag <= 1'b0;
      loop_source_flag <= 1'b0;
      loop_sink_flag <= 1'b0;
      back_emf_comparator_state <= 1'b0;
      loop_sink_q <= 1'b0;
    end else begin
      thermal_q <= thermal_i;
      supply_good_flag <= supply_good_i;
      loop_source_flag <= loop_source_i;
      loop_sink_flag <= loop_sink_i;
      back_emf_comparator_state <= back_emf_comparator_i;
      loop_sink_q <= loop_sink_flag;
    end
  end

  // down pulse is the rising edge of the sink flag
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      speed_reached_flag <= 1'b0;
    end else if (por_hold) begin
      speed_reached_flag <= 1'b0;
    end else if (loop_sink_flag && !loop_sink_q) begin
      speed_reached_flag <= 1'b1;
    end
  end

  assign system_status = {4'h0, speed_reached_flag, delay_active,
                          mask_active, back_emf_comparator_state,
                          loop_sink_flag, loop_source_flag,
                          supply_good_flag, thermal_q};

  ////////////////////////////////////////////////////////////////////////////
  // host reads

  // reads run off rst_n_i only, so status stays readable in undervoltage
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= `REG_RESET;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) begin
        if (addr_i == `IDX_SYSTEM_STATUS) begin
          rd_data_o <= system_status;
        end else begin
          rd_data_o <= `REG_RESET;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // coil current decode

  wire [9:0] coil_low;
  wire [10:0] coil_negated;

  assign coil_low = coil_current_command[`COIL_MAG_MSB:0];
  assign coil_negated = {1'b0, ~coil_low} + 11'h001;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      coil_magnitude_o <= 10'h000;
      coil_direction_o <= 1'b0;
      coil_range_select_o <= 1'b0;
    end else begin
      coil_direction_o <= coil_current_command[`COIL_DIR_BIT];
      coil_range_select_o <= coil_current_command[`COIL_RANGE_BIT];
      if (coil_current_command[`COIL_DIR_BIT]) begin
        if (coil_negated[10]) begin
          coil_magnitude_o <= `COIL_MAG_MAX;
        end else begin
          coil_magnitude_o <= coil_negated[9:0];
        end
      end else begin
        coil_magnitude_o <= coil_low;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // spindle control fields

  assign spin_current_limit_o = spindle_control[`SPIN_LIMIT_MSB:0];
  assign commutation_lag_o = spindle_control[`LAG_MSB:`LAG_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // zero crossing, lag delay and commutation

  reg bemf_prev;
  reg [`PERIOD_W-1:0] period_cnt;
  reg [`PERIOD_W-1:0] period_q;
  reg [`PERIOD_W-1:0] delay_cnt;
  reg [`PERIOD_W-1:0] mask_cnt;
  reg [2:0] step;
  wire zero_cross;
  wire delay_done;
  wire [`PERIOD_W+3:0] lag_product;
  wire [`PERIOD_W-1:0] delay_load;
  wire spin_off;

  assign spin_off = por_hold | thermal_q;
  assign mask_active = (mask_cnt != {`PERIOD_W{1'b0}});
  assign delay_active = (delay_cnt != {`PERIOD_W{1'b0}});

  assign zero_cross = (back_emf_comparator_state != bemf_prev) &&
                      !mask_active && !delay_active && !spin_off;

  assign lag_product = period_q * commutation_lag_o;
  assign delay_load =
    (lag_product[`PERIOD_W+3:`LAG_STEP_SHIFT] == {(`PERIOD_W-1){1'b0}}) ?
    {{(`PERIOD_W-1){1'b0}}, 1'b1} :
    {1'b0, lag_product[`PERIOD_W+3:`LAG_STEP_SHIFT]};

  assign delay_done = (delay_cnt == {{(`PERIOD_W-1){1'b0}}, 1'b1});
  assign commutate_o = delay_done;

  // step period measured between accepted crossings, saturating
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bemf_prev <= 1'b0;
      period_cnt <= {`PERIOD_W{1'b0}};
      period_q <= {`PERIOD_W{1'b0}};
    end else if (spin_off) begin
      bemf_prev <= back_emf_comparator_state;
      period_cnt <= {`PERIOD_W{1'b0}};
      period_q <= {`PERIOD_W{1'b0}};
    end else begin
      bemf_prev <= back_emf_comparator_state;
      if (zero_cross) begin
        period_q <= period_cnt;
        period_cnt <= {`PERIOD_W{1'b0}};
      end else if (period_cnt != {`PERIOD_W{1'b1}}) begin
        period_cnt <= period_cnt + {{(`PERIOD_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      delay_cnt <= {`PERIOD_W{1'b0}};
      mask_cnt <= {`PERIOD_W{1'b0}};
      step <= 3'h0;
    end else if (spin_off) begin
      delay_cnt <= {`PERIOD_W{1'b0}};
      mask_cnt <= {`PERIOD_W{1'b0}};
      step <= 3'h0;
    end else begin
      if (zero_cross) begin
        delay_cnt <= delay_load;
      end else if (delay_active) begin
        delay_cnt <= delay_cnt - {{(`PERIOD_W-1){1'b0}}, 1'b1};
      end
      // masking blanks switching noise right after each commutation
      if (delay_done) begin
        mask_cnt <= MASK_CYCLES[`PERIOD_W-1:0];
      end else if (mask_active) begin
        mask_cnt <= mask_cnt - {{(`PERIOD_W-1){1'b0}}, 1'b1};
      end
      if (delay_done) begin
        step <= (step == `STEP_LAST) ? 3'h0 : step + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // half-bridge drive table

  reg [2:0] next_high;
  reg [2:0] next_low;

  always @* begin
    case (step)
      3'h0: begin
        next_high = 3'b001;
        next_low = 3'b010;
      end
      3'h1: begin
        next_high = 3'b001;
        next_low = 3'b100;
      end
      3'h2: begin
        next_high = 3'b010;
        next_low = 3'b100;
      end
      3'h3: begin
        next_high = 3'b010;
        next_low = 3'b001;
      end
      3'h4: begin
        next_high = 3'b100;
        next_low = 3'b001;
      end
      3'h5: begin
        next_high = 3'b100;
        next_low = 3'b010;
      end
      default: begin
        next_high = 3'b000;
        next_low = 3'b000;
      end
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_drive_o <= 3'b000;
      low_drive_o <= 3'b000;
    end else if (spin_off) begin
      high_drive_o <= 3'b000;
      low_drive_o <= 3'b000;
    end else begin
      high_drive_o <= next_high;
      low_drive_o <= next_low;
    end
  end

endmodule

// >>> spindle_vcm_regs_defines.vh
// register indices, field positions, reset values and timing counts
`ifndef SPINDLE_VCM_REGS_DEFINES_VH
`define SPINDLE_VCM_REGS_DEFINES_VH

// register indices on the host port
`define ADDR_W 4
`define IDX_SYSTEM_STATUS 4'h0
`define IDX_COIL_CURRENT_COMMAND 4'h1
`define IDX_SPINDLE_CONTROL 4'h2

// register width and reset value
`define REG_W 12
`define REG_RESET 12'h000

// system_status bit positions
`define ST_THERMAL 0
`define ST_SUPPLY_GOOD 1
`define ST_LOOP_SOURCE 2
`define ST_LOOP_SINK 3
`define ST_BACK_EMF 4
`define ST_MASK 5
`define ST_DELAY 6
`define ST_SPEED_REACHED 7

// coil_current_command fields
`define COIL_MAG_MSB 9
`define COIL_DIR_BIT 10
`define COIL_RANGE_BIT 11
`define COIL_MAG_MAX 10'h3ff

// spindle_control fields
`define SPIN_LIMIT_MSB 7
`define LAG_LSB 8
`define LAG_MSB 11

// one lag step is 1.875 deg, i.e. 1/32 of a 60 deg commutation step
`define LAG_STEP_SHIFT 5

// commutation sequence
`define STEP_LAST 3'h5
`define MASK_CYCLES_DEFAULT 64
`define PERIOD_W 16

`endif

// >>> tb.sv
// self-checking bench for the register block
`timescale 1ns/100ps
module tb;
  reg clk, rst_n, thermal, sgood, src, sink, bemf;
  wire wr_en, rd_en, rd_valid, por, dir, rng, comm;
  wire [3:0] addr, lag;
  wire [11:0] wdata, rdata;
  wire [9:0] mag;
  wire [7:0] lim;
  wire [2:0] hi, lo;
  reg [11:0] q;
  integer fails, compares, cycles, i;
  localparam [71:0] CV = 72'h000_800_3ff_400_401_7ff;
  spindle_vcm_regs #(.MASK_CYCLES(4)) dut (.clk_i(clk), .rst_n_i(rst_n),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wr_data_i(wdata),
    .rd_data_o(rdata), .rd_valid_o(rd_valid), .thermal_i(thermal),
    .supply_good_i(sgood), .loop_source_i(src), .loop_sink_i(sink),
    .back_emf_comparator_i(bemf), .por_active_o(por),
    .coil_magnitude_o(mag), .coil_direction_o(dir),
    .coil_range_select_o(rng), .spin_current_limit_o(lim),
    .commutation_lag_o(lag), .high_drive_o(hi), .low_drive_o(lo),
    .commutate_o(comm));
  host_model host (.clk_i(clk), .wr_en_o(wr_en), .rd_en_o(rd_en),
    .addr_o(addr), .wr_data_o(wdata), .rd_data_i(rdata),
    .rd_valid_i(rd_valid));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input [11:0] seen, input [11:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      if (fails == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // expected {range, sign, magnitude} of a coil word
  function [11:0] dec(input [11:0] v);
    reg [10:0] n;
    begin
      n = ~v[10:0] + 11'h001;
      if (!v[10])
        dec = {v[11], 1'b0, v[9:0]};
      else
        dec = {v[11], 1'b1, (n[10] ? 10'h3ff : n[9:0])};
    end
  endfunction
  task t_coil;
    begin
      host.rd(4'h1, q);
      chk(q, 12'h000);
      chk({rng, dir, mag}, 12'h000);
      for (i = 0; i < 6; i = i + 1) begin
        host.wr(4'h1, CV[i*12 +: 12]);
        @(negedge clk);
        chk({rng, dir, mag}, dec(CV[i*12 +: 12]));
      end
    end
  endtask
  task t_spin;
    begin
      host.wr(4'h2, 12'ha5c);
      @(negedge clk);
      chk({lag, lim}, 12'ha5c);
      host.rd(4'h2, q);
      chk(q, 12'h000);
      host.rd(4'hf, q);
      chk(q, 12'h000);
    end
  endtask
  task t_status;
    begin
      {thermal, src, sink, bemf} = 4'b1111;
      repeat (3) @(negedge clk);
      chk({6'h00, hi, lo}, 12'h000);
      host.rd(4'h0, q);
      chk(q & 12'hf9f, 12'h09f);
      sink = 1'b0;
      host.wr(4'h0, 12'hfff);
      chk({rng, dir, mag}, 12'h000);
      host.rd(4'h0, q);
      chk(q & 12'hf9f, 12'h097);
      {thermal, src, bemf} = 3'b000;
      repeat (2) @(negedge clk);
      chk({11'h000, comm}, 12'h001);
      @(negedge clk);
      host.rd(4'h0, q);
      chk(q & 12'hf9f, 12'h082);
      chk(q, 12'h0a2);
      chk({6'h00, hi, lo}, 12'h00c);
    end
  endtask
  task t_uv;
    begin
      sgood = 1'b0;
      host.wr(4'h1, 12'h123);
      host.rd(4'h0, q);
      chk(q & 12'h002, 12'h000);
      chk({rng, dir, mag}, 12'h000);
      chk({11'h000, por}, 12'h001);
      sgood = 1'b1;
      q = 12'h000;
      while (q[1] !== 1'b1)
        host.rd(4'h0, q);
      chk(q & 12'h080, 12'h000);
      host.wr(4'h1, 12'h3ff);
      @(negedge clk);
      chk({rng, dir, mag}, 12'h3ff);
    end
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      close_out;
    end
  end
  initial begin
    {rst_n, thermal, src, sink, bemf} = 5'h00;
    sgood = 1'b1;
    {fails, compares, cycles} = 96'h0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_coil;
    t_spin;
    t_status;
    t_uv;
    close_out;
  end
endmodule

// >>> vcm_regs_props.sv
// assertions on the register block ports
`timescale 1ns/100ps
module vcm_regs_props #(
  parameter MASK_CYCLES = 64
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // host port
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [3:0] addr_i,
  input wire [11:0] wr_data_i,
  input wire [11:0] rd_data_o,
  // monitors and outputs
  input wire thermal_i,
  input wire supply_good_i,
  input wire por_active_o,
  input wire [9:0] coil_magnitude_o,
  input wire coil_direction_o,
  input wire coil_range_select_o,
  input wire [7:0] spin_current_limit_o,
  input wire [3:0] commutation_lag_o,
  input wire [2:0] high_drive_o,
  input wire [2:0] low_drive_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_coil_wr;
    wr_en_i && addr_i == 4'h1 && supply_good_i ##1 supply_good_i;
  endsequence
  sequence s_spin_wr;
    wr_en_i && addr_i == 4'h2 && supply_good_i ##1 supply_good_i;
  endsequence
  a_read_unmapped: assert property (rd_en_i && addr_i != 4'h0 |=>
    rd_data_o == 12'h000) else $error("unmapped read not zero");
  a_status_unused: assert property (rd_en_i && addr_i == 4'h0 |=>
    rd_data_o[11:8] == 4'h0) else $error("status high bits set");
  a_supply_bit: assert property (supply_good_i [*3] ##0
    rd_en_i && addr_i == 4'h0 |=> rd_data_o[1])
    else $error("supply good bit low");
  a_thermal_off: assert property (thermal_i [*3] |=>
    high_drive_o == 3'h0 && low_drive_o == 3'h0)
    else $error("drives on while hot");
  a_por_follows: assert property (por_active_o == !supply_good_i)
    else $error("reset flag wrong");
  a_uv_clears: assert property (!supply_good_i [*2] |=>
    coil_magnitude_o == 10'h000 && !coil_direction_o &&
    spin_current_limit_o == 8'h00 && commutation_lag_o == 4'h0)
    else $error("registers kept in undervoltage");
  a_coil_fields: assert property (s_coil_wr |=>
    coil_range_select_o == $past(wr_data_i[11], 2) &&
    coil_direction_o == $past(wr_data_i[10], 2) &&
    ($past(wr_data_i[10], 2) ||
    coil_magnitude_o == $past(wr_data_i[9:0], 2)))
    else $error("coil fields wrong");
  a_spin_fields: assert property (s_spin_wr |->
    spin_current_limit_o == $past(wr_data_i[7:0]) &&
    commutation_lag_o == $past(wr_data_i[11:8]))
    else $error("spindle fields wrong");
endmodule
bind spindle_vcm_regs vcm_regs_props #(.MASK_CYCLES(MASK_CYCLES)) props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
  .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
  .thermal_i(thermal_i), .supply_good_i(supply_good_i),
  .por_active_o(por_active_o), .coil_magnitude_o(coil_magnitude_o),
  .coil_direction_o(coil_direction_o),
  .coil_range_select_o(coil_range_select_o),
  .spin_current_limit_o(spin_current_limit_o),
  .commutation_lag_o(commutation_lag_o), .high_drive_o(high_drive_o),
  .low_drive_o(low_drive_o));
